// ==== src/autorange_pkg.sv ====
package autorange_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    // control field positions
    localparam int MODE_LSB = 0;
    localparam int AUTO_BIT = 2;
    localparam int IN_SW_LSB = 4;
    localparam int DIST_SW_LSB = 8;
    // status field positions
    localparam int ST_IN_LSB = 0;
    localparam int ST_DIST_LSB = 4;
    localparam int ST_OVER_BIT = 8;
    localparam int ST_UNDER_BIT = 9;
    localparam int ST_SUM_LSB = 12;
    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
    localparam logic [3:0] IN_COUNT_RESET = 4'h0;
    localparam logic [2:0] DIST_COUNT_RESET = 3'h0;
    // documented counter widths and ranges
    localparam int IN_WIDTH = 4;
    localparam int DIST_WIDTH = 3;
    localparam int SW_WIDTH = 3;
    localparam int SUM_WIDTH = 5;
    localparam logic [3:0] IN_MAX = 4'h9;
    localparam logic [2:0] DIST_MAX = 3'h7;
    // combined gain thresholds for the unit annunciators
    localparam logic [4:0] MV_FROM = 5'h03;
    localparam logic [4:0] UV_FROM = 5'h06;
    // readback wait
    localparam int APB_WAIT = 1;

    typedef enum logic [1:0]
    {
        MODE_LEVEL_V = 2'b00,
        MODE_LEVEL_DB = 2'b01,
        MODE_DIST_PCT = 2'b10,
        MODE_DIST_DB = 2'b11
    } mode_t;
endpackage : autorange_pkg

// ==== src/range_if.sv ====
interface range_if #(parameter int WIDTH = 4);
    logic over;
    logic under;
    logic load;
    logic [WIDTH-1:0] preset;
    logic [WIDTH-1:0] count;
    logic at_min;
    logic at_max;
    logic over_ind;
    logic under_ind;

    modport ctl (output over, under, load, preset,
        input count, at_min, at_max, over_ind, under_ind);
    modport ctr (input over, under, load, preset,
        output count, at_min, at_max, over_ind, under_ind);
endinterface : range_if

// ==== src/range_counter.sv ====
module range_counter
    import autorange_pkg::*;
#(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] MAX = '1,
    parameter logic [WIDTH-1:0] RESET_COUNT = '0
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    range_if.ctr r
);
    logic over_q;
    logic under_q;
    logic [WIDTH-1:0] count;

    // comparator pulses: rising edges step the counter
    wire over_step = r.over && !over_q;
    wire under_step = r.under && !under_q;
    wire at_min = (count == '0);
    wire at_max = (count == MAX);
    // active-low enable from the limit gating
    // over wins when both trip at once, so no wrap at the least sensitive end
    wire count_en_n = over_step ? at_min : !(under_step && !at_max); // [R5]
    wire [WIDTH-1:0] next_count = over_step ? count - 1'b1 : count + 1'b1; // [R4] [R6]

    // edge memory
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            over_q <= 1'b0;
            under_q <= 1'b0;
        end
        else if (ce)
        begin
            over_q <= r.over;
            under_q <= r.under;
        end
    end

    // preset load in manual, steps in auto
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count <= RESET_COUNT;
        else if (ce)
        begin
            if (r.load)
                count <= (r.preset > MAX) ? MAX : r.preset; // [R1]
            else if (!count_en_n)
                count <= next_count; // [R2] [R10]
        end
    end

    assign r.count = count;
    assign r.at_min = at_min;
    assign r.at_max = at_max;
    // limit gating outputs; over and under both suppressed in least sensitive range
    assign r.over_ind = r.over && !at_min; // [R7]
    assign r.under_ind = r.under && !at_min; // [R7]
endmodule : range_counter

// ==== src/apb_regs.sv ====
module apb_regs
    import autorange_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] status,
    output logic [31:0] ctrl,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // decode
    wire access = psel && penable && !pready;
    wire hit_ctrl = (paddr == CTRL_OFFSET);
    wire hit_status = (paddr == STATUS_OFFSET);
    wire mapped = hit_ctrl || hit_status;
    wire [31:0] read_word = hit_ctrl ? ctrl : (hit_status ? status : 32'h0000_0000);

    // one wait state, answer registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (ce)
        begin
            pready <= access;
            pslverr <= access && !mapped;
            prdata <= (access && !pwrite) ? read_word : 32'h0000_0000;
        end
    end

    // control register write, committed with the answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= CTRL_RESET;
        else if (ce && access && pwrite && hit_ctrl)
            ctrl <= pwdata & 32'h0000_0777;
    end
endmodule : apb_regs

// ==== src/autorange_gain_logic.sv ====
// Operation
// [R1] manual: input counter loads range switches
// [R2] auto: input counter steps from comparators
// [R3] input count decoded to decimal lines
// [R4] over-range counts down, less sensitive
// [R5] count only when active-low enable asserted
// [R6] under-range counts up, more sensitive
// [R7] active-high indicators, under suppressed at least
// [R8] level mode: indicators follow distortion stage too
// [R9] odd 10 dB step to amplifier, adder
// [R10] distortion gain autoranged the same way
// [R11] distortion source: level switch or distortion switches
// [R12] distortion count decoded three-to-eight
// [R13] adder sums input and distortion gains; code adds only dist_count[1:0] to in_count
// [R14] one of uV, mV, V lit
// [R15] decimal point: sum in volts, distortion gain
// [R16] dB modes: fixed decimal point lit
// [R17] offset source: sum in level, distortion
module autorange_gain_logic
    import autorange_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic in_over,
    input wire logic in_under,
    input wire logic dist_over,
    input wire logic dist_under,
    output logic [9:0] input_gain_lines,
    output logic [7:0] distortion_gain_lines,
    output logic odd_step,
    output logic over_led,
    output logic under_led,
    output logic uv_led,
    output logic mv_led,
    output logic v_led,
    output logic [2:0] decimal_points,
    output logic db_decimal_point,
    output logic [3:0] offset_select
);
    logic [31:0] ctrl;
    logic [31:0] status;

    range_if #(.WIDTH(IN_WIDTH)) in_r ();
    range_if #(.WIDTH(DIST_WIDTH)) dist_r ();

    // register file
    apb_regs regs
    (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .status(status),
        .ctrl(ctrl),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr)
    );

    // control fields
    wire mode_t mode = mode_t'(ctrl[MODE_LSB +: 2]);
    wire auto_range = ctrl[AUTO_BIT];
    wire [SW_WIDTH-1:0] input_range_switch = ctrl[IN_SW_LSB +: SW_WIDTH];
    wire [SW_WIDTH-1:0] dist_range_switch = ctrl[DIST_SW_LSB +: SW_WIDTH];
    wire level_mode = !mode[1];
    wire db_mode = mode[0];

    // input stage counter hookup
    assign in_r.over = in_over;
    assign in_r.under = in_under;
    assign in_r.load = !auto_range; // [R1]
    assign in_r.preset = {1'b0, input_range_switch}; // [R1]

    range_counter #(.WIDTH(IN_WIDTH), .MAX(IN_MAX), .RESET_COUNT(IN_COUNT_RESET))
        input_gain_counter
    (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .r(in_r)
    );

    // distortion gain source selector
    wire [SW_WIDTH-1:0] dist_source = level_mode ? input_range_switch : dist_range_switch; // [R11]
    assign dist_r.over = dist_over;
    assign dist_r.under = dist_under;
    assign dist_r.load = !auto_range;
    assign dist_r.preset = dist_source; // [R11]

    range_counter #(.WIDTH(DIST_WIDTH), .MAX(DIST_MAX), .RESET_COUNT(DIST_COUNT_RESET))
        distortion_gain_counter
    (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .r(dist_r) // [R10]
    );

    // decoders
    wire [IN_WIDTH-1:0] in_count = in_r.count;
    wire [DIST_WIDTH-1:0] dist_count = dist_r.count;
    wire [9:0] next_input_lines;
    wire [7:0] next_dist_lines;
    genvar i;
    generate
        for (i = 0; i < 10; i++)
        begin : g_in_dec
            assign next_input_lines[i] = (in_count == 4'(i)); // [R3]
        end
        for (i = 0; i < 8; i++)
        begin : g_dist_dec
            assign next_dist_lines[i] = (dist_count == 3'(i)); // [R12]
        end
    endgenerate

    // odd step and gain sum
    wire next_odd_step = in_count[0]; // [R9]
    wire [SUM_WIDTH-1:0] gain_sum = SUM_WIDTH'(in_count) + SUM_WIDTH'(dist_count[1:0]); // [R13]

    // unit annunciators, exactly one lit
    wire next_uv = (gain_sum >= UV_FROM); // [R14]
    wire next_mv = (gain_sum >= MV_FROM) && !next_uv; // [R14]
    wire next_v = (gain_sum < MV_FROM); // [R14]

    // decimal point position from sum or distortion gain
    wire [4:0] sum_mod = gain_sum % 5'h03;
    wire [2:0] dist_mod = dist_count % 3'h3;
    wire [1:0] dp_pos = level_mode ? sum_mod[1:0] : dist_mod[1:0]; // [R15]
    wire [2:0] next_dp = db_mode ? 3'h0 : (3'h1 << dp_pos); // [R15] [R16]

    // range indicators, level mode adds distortion stage
    wire next_over = in_r.over_ind || (level_mode && dist_r.over_ind); // [R7] [R8]
    wire next_under = in_r.under_ind || (level_mode && dist_r.under_ind); // [R7] [R8]

    // offset generator source
    wire [3:0] next_offset = level_mode ? gain_sum[3:0] : {1'b0, dist_count}; // [R17]

    assign status = {15'h0000, gain_sum, 2'h0, next_under, next_over, 1'h0,
        dist_count, in_count};

    // registered outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            input_gain_lines <= 10'h001;
            distortion_gain_lines <= 8'h01;
            odd_step <= 1'b0;
            over_led <= 1'b0;
            under_led <= 1'b0;
            uv_led <= 1'b0;
            mv_led <= 1'b0;
            v_led <= 1'b1;
            decimal_points <= 3'h1; // matches decoded sum 0 in volts mode
            db_decimal_point <= 1'b0;
            offset_select <= 4'h0;
        end
        else if (ce)
        begin
            input_gain_lines <= next_input_lines;
            distortion_gain_lines <= next_dist_lines;
            odd_step <= next_odd_step;
            over_led <= next_over;
            under_led <= next_under;
            uv_led <= next_uv;
            mv_led <= next_mv;
            v_led <= next_v;
            decimal_points <= next_dp;
            db_decimal_point <= db_mode; // [R16]
            offset_select <= next_offset;
        end
    end
endmodule : autorange_gain_logic

// ==== bench/autorange_gain_logic_properties.sv ====
module autorange_checker
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [9:0] input_gain_lines,
    input wire logic [7:0] distortion_gain_lines,
    input wire logic odd_step,
    input wire logic uv_led,
    input wire logic mv_led,
    input wire logic v_led,
    input wire logic [2:0] decimal_points,
    input wire logic db_decimal_point
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // bus answers after one wait state, for one cycle
    property p_answer;
        psel && penable && !pready && ce |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("apb answer missing");
    property p_pulse;
        pready && ce |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pready held too long");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("error without pready");
    // decoded gain lines
    property p_in_lines;
        $onehot(input_gain_lines);
    endproperty
    a_in_lines: assert property (p_in_lines) else $error("input lines not one-hot");
    property p_dist_lines;
        $onehot(distortion_gain_lines);
    endproperty
    a_dist_lines: assert property (p_dist_lines) else $error("dist lines not one-hot");
    property p_odd;
        odd_step == |(input_gain_lines & 10'h2aa);
    endproperty
    a_odd: assert property (p_odd) else $error("odd step wrong");
    // annunciators and decimal points
    property p_unit;
        $onehot({uv_led, mv_led, v_led});
    endproperty
    a_unit: assert property (p_unit) else $error("unit leds not one-hot");
    property p_point;
        db_decimal_point ? decimal_points == 3'h0 : $onehot(decimal_points);
    endproperty
    a_point: assert property (p_point) else $error("decimal point wrong");
endmodule : autorange_checker

bind autorange_gain_logic autorange_checker autorange_checker_inst (.pclk, .presetn, .ce,
    .psel, .penable, .pready, .pslverr, .input_gain_lines, .distortion_gain_lines,
    .odd_step, .uv_led, .mv_led, .v_led, .decimal_points, .db_decimal_point);

// ==== bench/comparator_model.sv ====
module comparator_model
(
    input wire logic pclk,
    input wire logic [3:0] req,
    input wire logic [3:0] hold,
    output logic in_over,
    output logic in_under,
    output logic dist_over,
    output logic dist_under
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] pulse;
    // one-cycle comparator trip per request
    always_ff @(posedge pclk)
    begin
        pulse <= req;
    end
    // trip or steady level toward the counters
    assign {dist_under, dist_over, in_under, in_over} = pulse | hold;
endmodule : comparator_model

// ==== bench/tb.sv ====
module tb
    import autorange_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic [31:0] ctrl; logic [28:0] exp;} row_t;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, odd_step, over_led, under_led, uv_led, mv_led, v_led;
    logic in_over, in_under, dist_over, dist_under, db_decimal_point;
    logic [9:0] input_gain_lines;
    logic [7:0] distortion_gain_lines;
    logic [2:0] decimal_points;
    logic [3:0] offset_select, req = '0, hold = '0;
    int n_errors = 0, n_compared = 0, cycles = 0;
    // manual settings, five rows covering all four modes, sums 2..10
    row_t rows [5] = '{
        '{32'h0000_0020, {10'h004, 8'h04, 3'h2, 3'h2, 1'h0, 4'h4}},
        '{32'h0000_0071, {10'h080, 8'h80, 3'h4, 3'h0, 1'h1, 4'ha}},
        '{32'h0000_0512, {10'h002, 8'h20, 3'h1, 3'h4, 1'h0, 4'h5}},
        '{32'h0000_0703, {10'h001, 8'h80, 3'h2, 3'h0, 1'h1, 4'h7}},
        '{32'h0000_0050, {10'h020, 8'h20, 3'h4, 3'h1, 1'h0, 4'h6}}};
    autorange_gain_logic autorange_gain_logic_inst (.pclk, .presetn, .ce, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .in_over, .in_under,
        .dist_over, .dist_under, .input_gain_lines, .distortion_gain_lines, .odd_step,
        .over_led, .under_led, .uv_led, .mv_led, .v_led, .decimal_points,
        .db_decimal_point, .offset_select);
    comparator_model comparator_model_inst (.pclk, .req, .hold, .in_over, .in_under,
        .dist_over, .dist_under);
    // grouped views of the outputs for the row checks
    wire [17:0] gain_seen = {input_gain_lines, distortion_gain_lines};
    wire [10:0] disp_seen = {uv_led, mv_led, v_led, decimal_points, db_decimal_point,
        offset_select};
    always #5 pclk = ~pclk;
    // hang guard
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            conclude();
        end
    end
    task automatic conclude;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask : chk
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic settle;
        repeat (3) @(posedge pclk);
        #1;
    endtask : settle
    // one comparator trip: 0 in over, 1 in under, 2 dist over, 3 dist under
    task automatic trip(input int i);
        @(posedge pclk);
        req <= 4'h1 << i;
        @(posedge pclk);
        req <= 4'h0;
        settle();
    endtask : trip
    task automatic do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset
    initial
    begin
        do_reset();
        foreach (rows[i])
        begin
            apb(1'b1, CTRL_OFFSET, rows[i].ctrl);
            settle();
            chk("gain lines", 32'(rows[i].exp[28:11]), 32'(gain_seen));
            chk("panel", 32'(rows[i].exp[10:0]), 32'(disp_seen));
        end
        // second reset, then auto ranging from the ends
        do_reset();
        settle();
        chk("reset", 32'h0000_0401, {21'h0, v_led, input_gain_lines});
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk("ctrl reset", CTRL_RESET, rd);
        trip(0);
        chk("over at least", 32'h0000_0001, {22'h0, input_gain_lines});
        repeat (3) trip(1);
        trip(0);
        chk("down", 32'h0000_0004, {22'h0, input_gain_lines});
        repeat (8) trip(1);
        chk("at most", 32'h0000_0200, {22'h0, input_gain_lines});
        chk("odd step", 32'h0000_0001, {31'h0, odd_step});
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk("status count", 32'h0000_0009, {28'h0, rd[3:0]});
        trip(2);
        repeat (2) trip(3);
        chk("dist count", 32'h0000_0004, {24'h0, distortion_gain_lines});
        apb(1'b0, 8'h08, 32'h0);
        chk("unmapped", 32'h0000_0001, {rd[30:0], err});
        apb(1'b1, STATUS_OFFSET, 32'hffff_ffff);
        chk("status write", 32'h0, {31'h0, err});
        // manual indicators
        apb(1'b1, CTRL_OFFSET, 32'h0);
        hold <= 4'h2;
        settle();
        chk("under least", 32'h0, {31'h0, under_led});
        apb(1'b1, CTRL_OFFSET, 32'h0000_0030);
        settle();
        chk("under", 32'h0000_0001, {31'h0, under_led});
        trip(0);
        chk("manual hold", 32'h0000_0008, {22'h0, input_gain_lines});
        @(posedge pclk);
        hold <= 4'h4;
        settle();
        chk("level over", 32'h0000_0001, {31'h0, over_led});
        apb(1'b1, CTRL_OFFSET, 32'h0000_0332);
        settle();
        chk("dist mode over", 32'h0, {31'h0, over_led});
        conclude();
    end
endmodule : tb
